// ---- hw/bcc_bus_cycle_controller.sv ----
// Purpose: paces each core bus access: address cycle, wait cycles, rest
//          of the basic cycle, then hold cycles; holds timing registers
// Assumes: cpu request comes from logic on the same clock and is held
//          until acknowledged; registers reached over avalon-mm
// Notes:   one access at a time; ack is a registered one-cycle pulse
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps

module bcc_bus_cycle_controller
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // core bus request and answer
    input wire logic cpu_req_in,
    input wire bcc_pkg::bcc_cpu_req_s cpu_cmd_in,
    output logic cpu_ack_out,
    output logic [15:0] cpu_rdata_out,
    // on-chip memory side
    output bcc_pkg::bcc_mem_s mem_out,
    input wire logic [15:0] mem_rdata_in,
    // register bus
    input wire logic [15:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out
);

    // whole module state in one record
    typedef struct packed {
        bcc_pkg::bcc_phase_e phase;
        bcc_pkg::bcc_cpu_req_s cmd;
        logic [3:0] wait_cnt;
        logic [1:0] basic_cnt;
        logic [1:0] hold_cnt;
        logic [15:0] rdata;
        logic ack;
        logic [7:0] wmode;
        logic [15:0] zone0;
        logic [15:0] aux;
        logic av_done;
        logic [31:0] av_rdata;
    } bcc_state_s;

    bcc_state_s cur_ff; // registered state
    bcc_state_s nxt_cur; // next state
    bcc_pkg::bcc_timing_s plan; // timing of the request being taken
    logic av_req; // register bus request present
    logic end_basic; // last clock of the basic cycle
    logic [31:0] rd_mux; // register read value

    // register bus request; a write only lands on the answering edge
    assign av_req = avs_read_in | avs_write_in;

    // every access answers in its second clock
    assign avs_waitrequest_out = av_req & ~cur_ff.av_done;
    assign avs_readdata_out = cur_ff.av_rdata;

    // answer to the cpu comes from flops so the data is stable with it
    assign cpu_ack_out = cur_ff.ack;
    assign cpu_rdata_out = cur_ff.rdata;

    // memory strobes are decoded from the phase, lines from flops
    always_comb
    begin
        mem_out.addr = cur_ff.cmd.addr;
        mem_out.wdata = cur_ff.cmd.wdata;
        // strobes stay up through holds so data stays on the bus
        mem_out.rd = (cur_ff.phase != bcc_pkg::BCC_IDLE) & ~cur_ff.cmd.we;
        mem_out.wr = (cur_ff.phase != bcc_pkg::BCC_IDLE) & cur_ff.cmd.we;
        mem_out.drive = mem_out.wr;
    end

    // timing plan for the request now on the bus
    assign plan = bcc_pkg::bcc_timing(cpu_cmd_in.addr, cpu_cmd_in.we,
        cur_ff.wmode, cur_ff.zone0, cur_ff.aux);

    // last basic clock: address cycle or last wait with nothing after, or last data
    always_comb
    begin
        end_basic = 1'b0;
        case (cur_ff.phase)
            bcc_pkg::BCC_ADDR:
                end_basic = (cur_ff.wait_cnt == 4'h0)
                    & (cur_ff.basic_cnt == 2'h0);
            bcc_pkg::BCC_WAIT:
                end_basic = (cur_ff.wait_cnt == 4'h1)
                    & (cur_ff.basic_cnt == 2'h0);
            bcc_pkg::BCC_DATA:
                end_basic = (cur_ff.basic_cnt == 2'h1);
            default:
                end_basic = 1'b0;
        endcase
    end

    // register read decode; unmapped offsets read zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (avs_address_in)
            bcc_pkg::BCC_WMODE_OFS:
                rd_mux = {24'h00_0000, cur_ff.wmode};
            bcc_pkg::BCC_ZONE0_OFS:
                rd_mux = {16'h0000, cur_ff.zone0};
            bcc_pkg::BCC_AUX_OFS:
                rd_mux = {16'h0000, cur_ff.aux};
            bcc_pkg::BCC_STAT_OFS:
                // live phase and remaining waits for software to watch
                rd_mux = {20'h0_0000, cur_ff.wait_cnt, 2'h0,
                    cur_ff.phase, (cur_ff.phase != bcc_pkg::BCC_IDLE)};
            default:
                rd_mux = 32'h0000_0000;
        endcase
    end

    // next state of the bus cycle and the register file
    always_comb
    begin
        nxt_cur = cur_ff;
        nxt_cur.ack = 1'b0;

        // bus cycle sequencing
        case (cur_ff.phase)
            bcc_pkg::BCC_IDLE:
            begin
                // the ack cycle still sees the old request, so skip it
                if (cpu_req_in && !cur_ff.ack)
                begin
                    nxt_cur.cmd = cpu_cmd_in;
                    nxt_cur.wait_cnt = plan.waits;
                    nxt_cur.basic_cnt = plan.basic_rem;
                    nxt_cur.hold_cnt = plan.holds;
                    nxt_cur.phase = bcc_pkg::BCC_ADDR;
                end
            end
            bcc_pkg::BCC_ADDR:
            begin
                // waits come straight after the address cycle
                if (cur_ff.wait_cnt != 4'h0)
                begin
                    nxt_cur.phase = bcc_pkg::BCC_WAIT;
                end
                else if (cur_ff.basic_cnt != 2'h0)
                begin
                    nxt_cur.phase = bcc_pkg::BCC_DATA;
                end
            end
            bcc_pkg::BCC_WAIT:
            begin
                nxt_cur.wait_cnt = cur_ff.wait_cnt - 4'h1;
                if (cur_ff.wait_cnt == 4'h1 && cur_ff.basic_cnt != 2'h0)
                begin
                    nxt_cur.phase = bcc_pkg::BCC_DATA;
                end
            end
            bcc_pkg::BCC_DATA:
            begin
                // remaining clocks of the basic read or write cycle
                nxt_cur.basic_cnt = cur_ff.basic_cnt - 2'h1;
            end
            bcc_pkg::BCC_HOLD:
            begin
                // holds go on the end, strobes and data still driven
                nxt_cur.hold_cnt = cur_ff.hold_cnt - 2'h1;
                if (cur_ff.hold_cnt == 2'h1)
                begin
                    nxt_cur.phase = bcc_pkg::BCC_IDLE;
                    nxt_cur.ack = 1'b1;
                end
            end
            default:
            begin
                // illegal code: drop back to a safe idle
                nxt_cur.phase = bcc_pkg::BCC_IDLE;
            end
        endcase

        // close of the basic cycle: take read data, then hold or finish
        if (end_basic)
        begin
            nxt_cur.rdata = cur_ff.cmd.we ? cur_ff.rdata : mem_rdata_in;
            if (cur_ff.hold_cnt != 2'h0)
            begin
                nxt_cur.phase = bcc_pkg::BCC_HOLD;
            end
            else
            begin
                nxt_cur.phase = bcc_pkg::BCC_IDLE;
                nxt_cur.ack = 1'b1;
            end
        end

        // register bus: read data sampled in the first clock
        nxt_cur.av_done = av_req & ~cur_ff.av_done;
        nxt_cur.av_rdata = rd_mux;

        // writes take effect on the edge that sees waitrequest low
        if (avs_write_in && cur_ff.av_done)
        begin
            case (avs_address_in)
                bcc_pkg::BCC_WMODE_OFS:
                begin
                    if (avs_byteenable_in[0])
                    begin
                        nxt_cur.wmode = avs_writedata_in[7:0]
                            & bcc_pkg::BCC_WMODE_MASK;
                    end
                end
                bcc_pkg::BCC_ZONE0_OFS:
                begin
                    // two byte lanes of a word-wide register
                    if (avs_byteenable_in[0])
                    begin
                        nxt_cur.zone0[7:0] = avs_writedata_in[7:0]
                            & bcc_pkg::BCC_ZONE0_MASK[7:0];
                    end
                    if (avs_byteenable_in[1])
                    begin
                        nxt_cur.zone0[15:8] = avs_writedata_in[15:8]
                            & bcc_pkg::BCC_ZONE0_MASK[15:8];
                    end
                end
                bcc_pkg::BCC_AUX_OFS:
                begin
                    if (avs_byteenable_in[0])
                    begin
                        nxt_cur.aux[7:0] = avs_writedata_in[7:0]
                            & bcc_pkg::BCC_AUX_MASK[7:0];
                    end
                    if (avs_byteenable_in[1])
                    begin
                        nxt_cur.aux[15:8] = avs_writedata_in[15:8]
                            & bcc_pkg::BCC_AUX_MASK[15:8];
                    end
                end
                default:
                begin
                    // status and unmapped offsets ignore writes
                    nxt_cur.aux = cur_ff.aux;
                end
            endcase
        end
    end

    // state register; reset values select normal reads and early writes
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            cur_ff.phase <= bcc_pkg::BCC_IDLE;
            cur_ff.cmd <= '0;
            cur_ff.wait_cnt <= 4'h0;
            cur_ff.basic_cnt <= 2'h0;
            cur_ff.hold_cnt <= 2'h0;
            cur_ff.rdata <= 16'h0000;
            cur_ff.ack <= 1'b0;
            cur_ff.wmode <= bcc_pkg::BCC_WMODE_RST;
            cur_ff.zone0 <= bcc_pkg::BCC_ZONE0_RST;
            cur_ff.aux <= bcc_pkg::BCC_AUX_RST;
            cur_ff.av_done <= 1'b0;
            cur_ff.av_rdata <= 32'h0000_0000;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

endmodule

// ---- hw/bcc_pkg.sv ----
// Purpose: constants, types and the timing function of the bus cycle
//          controller that paces core bus accesses to on-chip memories
// Assumes: one clock, synchronous active-high reset, 16-bit address space
// Notes:   register offsets are byte addresses on the register bus
// Operation
// - normal read two clocks, fast read one
// - reset leaves fast read disabled
// - late write two clocks, early write three
// - wait cycles follow the address cycle directly
// - hold cycles extend the end, data driven
// - write mode register at f900, resets 07
// - bit 0 picks late or early write
// - zone 0 timing register at f904, resets 069f
// - zone 0 wait field 0..7, unused in fast
// - zone 0 hold field 0..3, unused in fast
// - fast read enable bit selects one-clock reads
// - fast flash read has no wait, no hold
// - normal flash read waits wait+1, holds hold
// - flash write in fast mode waits one
// - flash write waits wait+1 or wait+2, holds
// - ram accesses have no waits, no holds
// - data eeprom zero or one wait, no hold
// - eeprom select one means no wait
// - core and peripheral space uses one wait
// - port block timing from port timing config
// - port waits one plus wait, writes add mode

package bcc_pkg;

    // register byte offsets
    localparam logic [15:0] BCC_WMODE_OFS = 16'hf900;
    localparam logic [15:0] BCC_ZONE0_OFS = 16'hf904;
    localparam logic [15:0] BCC_AUX_OFS = 16'hf908;
    localparam logic [15:0] BCC_STAT_OFS = 16'hf90c;

    // values after reset
    localparam logic [7:0] BCC_WMODE_RST = 8'h07;
    localparam logic [15:0] BCC_ZONE0_RST = 16'h069f;
    localparam logic [15:0] BCC_AUX_RST = 16'h001f;

    // writable bits; reserved bits stay zero
    localparam logic [7:0] BCC_WMODE_MASK = 8'h07;
    localparam logic [15:0] BCC_ZONE0_MASK = 16'h0eff;
    localparam logic [15:0] BCC_AUX_MASK = 16'h011f;

    // field positions
    localparam int BCC_EWR_BIT = 0;
    localparam int BCC_Z0_WAIT_LSB = 0;
    localparam int BCC_Z0_HOLD_LSB = 3;
    localparam int BCC_FRE_BIT = 11;
    localparam int BCC_PT_WAIT_LSB = 0;
    localparam int BCC_PT_HOLD_LSB = 3;
    localparam int BCC_EE_SEL_BIT = 8;

    // address ranges
    localparam logic [15:0] BCC_FLASH_HI = 16'hbfff;
    localparam logic [15:0] BCC_RAM_LO = 16'hc000;
    localparam logic [15:0] BCC_RAM_HI = 16'hcbff;
    localparam logic [15:0] BCC_EE_LO = 16'hf000;
    localparam logic [15:0] BCC_EE_HI = 16'hf27f;
    localparam logic [15:0] BCC_PORT_LO = 16'hfb00;
    localparam logic [15:0] BCC_PORT_HI = 16'hfbff;

    // basic cycle lengths in clocks, stored as cycles after the first
    localparam logic [1:0] BCC_FAST_RD_REM = 2'h0;
    localparam logic [1:0] BCC_NORM_RD_REM = 2'h1;
    localparam logic [1:0] BCC_LATE_WR_REM = 2'h1;
    localparam logic [1:0] BCC_EARLY_WR_REM = 2'h2;

    // fixed wait counts of the simple regions
    localparam logic [3:0] BCC_ONE_WAIT = 4'h1;
    localparam logic [3:0] BCC_NO_WAIT = 4'h0;

    // bus cycle phases, one-hot
    typedef enum logic [4:0] {
        BCC_IDLE = 5'h01,
        BCC_ADDR = 5'h02,
        BCC_WAIT = 5'h04,
        BCC_DATA = 5'h08,
        BCC_HOLD = 5'h10
    } bcc_phase_e;

    // core bus request held by the cpu
    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } bcc_cpu_req_s;

    // strobes and lines toward the on-chip memories
    typedef struct packed {
        logic rd;
        logic wr;
        logic drive;
        logic [15:0] addr;
        logic [15:0] wdata;
    } bcc_mem_s;

    // per-access cycle plan
    typedef struct packed {
        logic [3:0] waits;
        logic [1:0] basic_rem;
        logic [1:0] holds;
    } bcc_timing_s;

    // works out waits, basic length and holds for one access
    function automatic bcc_timing_s bcc_timing(
        input logic [15:0] addr,
        input logic we,
        input logic [7:0] wmode,
        input logic [15:0] zone0,
        input logic [15:0] aux
    );
        bcc_timing_s t;
        logic fast_read_enable;
        logic early_write_select;
        logic [3:0] zw;
        logic [3:0] pw;
        fast_read_enable = zone0[BCC_FRE_BIT];
        early_write_select = wmode[BCC_EWR_BIT];
        zw = {1'b0, zone0[BCC_Z0_WAIT_LSB +: 3]};
        pw = {1'b0, aux[BCC_PT_WAIT_LSB +: 3]};
        // core registers, peripherals and unlisted space
        t.waits = BCC_ONE_WAIT;
        t.holds = 2'h0;
        // basic length from direction and write mode
        t.basic_rem = we ? (early_write_select ? BCC_EARLY_WR_REM : BCC_LATE_WR_REM)
                         : BCC_NORM_RD_REM;
        if (addr <= BCC_FLASH_HI)
        begin
            if (!we && fast_read_enable)
            begin
                t.basic_rem = BCC_FAST_RD_REM;
                t.waits = BCC_NO_WAIT;
            end
            else if (!we)
            begin
                t.waits = zw + 4'h1;
                t.holds = zone0[BCC_Z0_HOLD_LSB +: 2];
            end
            else if (fast_read_enable)
            begin
                t.waits = BCC_ONE_WAIT;
            end
            else
            begin
                t.waits = zw + 4'h1 + {3'h0, early_write_select};
                t.holds = zone0[BCC_Z0_HOLD_LSB +: 2];
            end
        end
        else if (addr >= BCC_RAM_LO && addr <= BCC_RAM_HI)
        begin
            t.waits = BCC_NO_WAIT;
        end
        else if (addr >= BCC_EE_LO && addr <= BCC_EE_HI)
        begin
            // select bit set means the memory is fast enough
            t.waits = aux[BCC_EE_SEL_BIT] ? BCC_NO_WAIT
                                          : BCC_ONE_WAIT;
        end
        else if (addr >= BCC_PORT_LO && addr <= BCC_PORT_HI)
        begin
            t.waits = we ? pw + 4'h1 + {3'h0, early_write_select}
                         : pw + 4'h1;
            t.holds = aux[BCC_PT_HOLD_LSB +: 2];
        end
        return t;
    endfunction

endpackage

// ---- tb/bcc_bus_cycle_controller_bench.sv ----
// Purpose: random and corner tests of the bus cycle controller
// Assumes: one core access at a time; memory model answers at once
// Notes: expected clock counts are worked out here from the timing rules
`timescale 1ns/1ps
module bcc_bus_cycle_controller_bench;
    logic clk_sys_in = 1'b0; // system clock
    logic srst_in = 1'b1; // reset
    logic cpu_req_in = 1'b0; // core request
    bcc_pkg::bcc_cpu_req_s cpu_cmd_in = 33'h0; // core command
    logic cpu_ack_out;
    logic [15:0] cpu_rdata_out;
    bcc_pkg::bcc_mem_s mem_out;
    logic [15:0] mem_rdata_in;
    logic [15:0] last_wdata; // word the memory last saw
    logic [15:0] avs_address_in = 16'h0;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [3:0] avs_byteenable_in = 4'h0;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic [7:0] wm; // expected register contents
    logic [15:0] z0;
    logic [15:0] ax;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0; // watchdog count
    always #12.5 clk_sys_in = ~clk_sys_in;
    bcc_bus_cycle_controller u_bcc_bus_cycle_controller (
        .clk_sys_in(clk_sys_in), .srst_in(srst_in),
        .cpu_req_in(cpu_req_in), .cpu_cmd_in(cpu_cmd_in),
        .cpu_ack_out(cpu_ack_out), .cpu_rdata_out(cpu_rdata_out),
        .mem_out(mem_out), .mem_rdata_in(mem_rdata_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out));
    bcc_mem_model u_bcc_mem_model (.clk_sys_in(clk_sys_in),
        .mem_in(mem_out), .rdata_out(mem_rdata_in), .wdata_out(last_wdata));
    // clocks from taken edge to the edge that sees ack
    function automatic int exp_clk(input logic we, input logic [15:0] a);
        int w;
        int h;
        int b;
        h = 0;
        b = we ? (wm[0] ? 3 : 2) : 2;
        w = 1; // core and unlisted space
        if (a <= 16'hbfff)
        begin
            if (!we && z0[11])
            begin
                b = 1;
                w = 0;
            end
            else if (!z0[11])
            begin
                w = 1 + z0[2:0] + (we ? wm[0] : 0);
                h = z0[4:3];
            end
        end
        else if (a >= 16'hc000 && a <= 16'hcbff)
            w = 0;
        else if (a >= 16'hf000 && a <= 16'hf27f)
            w = ax[8] ? 0 : 1;
        else if (a >= 16'hfb00 && a <= 16'hfbff)
        begin
            w = 1 + ax[2:0] + (we ? wm[0] : 0);
            h = ax[4:3];
        end
        return b + w + h + 1;
    endfunction
    // value compare
    task automatic chk_val(input string n, input logic [31:0] e,
        input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // clock count compare
    task automatic chk_clk(input string n, input int e, input int g);
        num_checks++;
        if (g != e)
        begin
            err_total++;
            $display("wrong value %s expected %0d seen %0d", n, e, g);
        end
    endtask
    // one avalon access; held until waitrequest is seen low
    task automatic av_op(input logic wr, input logic [15:0] a,
        input logic [15:0] d, input logic [3:0] be, output logic [31:0] q);
        @(posedge clk_sys_in);
        avs_address_in <= a;
        avs_read_in <= !wr;
        avs_write_in <= wr;
        avs_writedata_in <= {16'h0, d};
        avs_byteenable_in <= be;
        do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask
    // register write, keeping the expected copies in step
    task automatic reg_wr(input logic [15:0] a, input logic [15:0] d,
        input logic [3:0] be);
        logic [31:0] q;
        logic [15:0] m;
        m = {{8{be[1]}}, {8{be[0]}}};
        av_op(1'b1, a, d, be, q);
        if (a == bcc_pkg::BCC_WMODE_OFS)
            wm = (wm & ~m[7:0]) | (d[7:0] & m[7:0] & bcc_pkg::BCC_WMODE_MASK);
        if (a == bcc_pkg::BCC_ZONE0_OFS)
            z0 = (z0 & ~m) | (d & m & bcc_pkg::BCC_ZONE0_MASK);
        if (a == bcc_pkg::BCC_AUX_OFS)
            ax = (ax & ~m) | (d & m & bcc_pkg::BCC_AUX_MASK);
    endtask
    task automatic reg_rd(input logic [15:0] a, input logic [31:0] e);
        logic [31:0] q;
        av_op(1'b0, a, 16'h0, 4'h3, q);
        chk_val("register read", e, q);
    endtask
    // one core access: clock count and data checked
    task automatic cpu_op(input logic we, input logic [15:0] a,
        input logic [15:0] d);
        int n;
        int e;
        e = exp_clk(we, a);
        @(posedge clk_sys_in);
        cpu_req_in <= 1'b1;
        cpu_cmd_in <= '{we, a, d};
        @(posedge clk_sys_in);
        n = 0;
        do
        begin
            @(posedge clk_sys_in);
            n++;
        end
        while (cpu_ack_out !== 1'b1 && n < 40);
        cpu_req_in <= 1'b0;
        chk_clk("bus cycle clocks", e, n);
        if (!we)
            chk_val("read data", a ^ 16'ha5a5, cpu_rdata_out);
        else
            chk_val("written data", d, last_wdata);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // cut a hang short
    always @(posedge clk_sys_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            results();
        end
    end
    // main sequence
    initial
    begin
        logic [31:0] r;
        logic [15:0] base [6];
        base = '{16'h0000, 16'hc000, 16'hf000, 16'hf800, 16'hfb00, 16'hfc00};
        void'($urandom(49));
        wm = bcc_pkg::BCC_WMODE_RST;
        z0 = bcc_pkg::BCC_ZONE0_RST;
        ax = bcc_pkg::BCC_AUX_RST;
        repeat (6) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        reg_rd(bcc_pkg::BCC_WMODE_OFS, 32'h07);
        reg_rd(bcc_pkg::BCC_ZONE0_OFS, 32'h069f);
        reg_rd(16'hf9f0, 32'h0);
        cpu_op(1'b0, 16'h0100, 16'h0);
        cpu_op(1'b1, 16'hc010, 16'h1357);
        $display("test reset timing done");
        reg_wr(bcc_pkg::BCC_WMODE_OFS, 16'h06, 4'h1);
        reg_rd(bcc_pkg::BCC_WMODE_OFS, 32'h06);
        cpu_op(1'b1, 16'hc7fe, 16'h2468);
        reg_wr(bcc_pkg::BCC_ZONE0_OFS, 16'hff80, 4'h1);
        reg_rd(bcc_pkg::BCC_ZONE0_OFS, 32'h0680);
        $display("test late write done");
        for (int i = 0; i < 60; i++)
        begin
            r = (i == 0) ? 32'h0 : $urandom;
            reg_wr(bcc_pkg::BCC_ZONE0_OFS, 16'h0680 | {4'h0, r[0], 6'h0,
                r[5:1]}, 4'h3);
            reg_wr(bcc_pkg::BCC_WMODE_OFS, {8'h0, 7'h03, r[6]}, 4'h1);
            reg_wr(bcc_pkg::BCC_AUX_OFS, {7'h0, r[7], 3'h0, r[12:8]}, 4'h3);
            reg_rd(bcc_pkg::BCC_ZONE0_OFS, {16'h0, z0});
            reg_rd(bcc_pkg::BCC_AUX_OFS, {16'h0, ax});
            for (int k = 0; k < 3; k++)
            begin
                r = $urandom;
                cpu_op(r[13], base[r[18:16] % 6] | {8'h0, r[7:1], 1'b0},
                    r[31:16]);
            end
            foreach (base[j])
                cpu_op(j[0], base[j] + 16'hfe, 16'h55aa);
        end
        $display("test random timing done");
        reg_rd(bcc_pkg::BCC_STAT_OFS, 32'h2);
        // second reset in mid-run must bring back the slow defaults
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        wm = bcc_pkg::BCC_WMODE_RST;
        z0 = bcc_pkg::BCC_ZONE0_RST;
        ax = bcc_pkg::BCC_AUX_RST;
        reg_rd(bcc_pkg::BCC_AUX_OFS, 32'h001f);
        cpu_op(1'b0, 16'hbffe, 16'h0);
        cpu_op(1'b0, 16'hcbfe, 16'h0);
        cpu_op(1'b0, 16'hf27e, 16'h0);
        cpu_op(1'b0, 16'hf280, 16'h0);
        cpu_op(1'b1, 16'hfbfe, 16'hf0f0);
        $display("test boundaries done");
        results();
    end
endmodule
bind bcc_bus_cycle_controller bcc_props u_bcc_props (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .cpu_ack_out(cpu_ack_out),
    .mem_out(mem_out), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_waitrequest_out(avs_waitrequest_out));

// ---- tb/bcc_mem_model.sv ----
// Purpose: behavioural on-chip memory facing the controller
// Assumes: read data follow the strobed address in the same clock
// Notes: off a read the data lines change every clock
`timescale 1ns/1ps
module bcc_mem_model
(
    // clock
    input wire logic clk_sys_in,
    // controller side
    input wire bcc_pkg::bcc_mem_s mem_in,
    output logic [15:0] rdata_out,
    // last written word, for the bench
    output logic [15:0] wdata_out
);
    logic [15:0] junk_ff = 16'h1234; // noise so stale data never matches
    // data only while selected
    assign rdata_out = mem_in.rd ? mem_in.addr ^ 16'ha5a5 : junk_ff;
    // noise steps each clock; writes latched while strobed
    always_ff @(posedge clk_sys_in)
    begin
        junk_ff <= junk_ff + 16'h3b1d;
        if (mem_in.wr)
            wdata_out <= mem_in.wdata;
    end
endmodule

// ---- tb/bcc_props.sv ----
// Purpose: port timing checks on the bus cycle controller
// Assumes: shadows of the write mode and fast read bits follow reg writes
// Notes: only ram, core and fast flash paths are timed here
`timescale 1ns/1ps
module bcc_props
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // core bus answer
    input wire logic cpu_ack_out,
    // memory side
    input wire bcc_pkg::bcc_mem_s mem_out,
    // register bus
    input wire logic [15:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic avs_waitrequest_out
);
    logic ewr_ff; // early write shadow
    logic fre_ff; // fast read shadow
    logic wr_ok; // register write taken at this edge
    logic in_ram; // strobed address is ram
    logic in_core; // strobed address is core space
    assign wr_ok = avs_write_in && !avs_waitrequest_out;
    assign in_ram = mem_out.addr >= 16'hc000 && mem_out.addr <= 16'hcbff;
    assign in_core = mem_out.addr >= 16'hf800 && mem_out.addr <= 16'hfaff;
    // shadows track only accepted writes, so a stalled write changes nothing
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            ewr_ff <= 1'b1;
            fre_ff <= 1'b0;
        end
        else
        begin
            if (wr_ok && avs_address_in == 16'hf900 && avs_byteenable_in[0])
                ewr_ff <= avs_writedata_in[0];
            if (wr_ok && avs_address_in == 16'hf904 && avs_byteenable_in[1])
                fre_ff <= avs_writedata_in[11];
        end
    end
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (srst_in);
    ack_pulse_a: assert property (cpu_ack_out |=> !cpu_ack_out)
        else $error("ack longer than one clock");
    ram_read_a: assert property ($rose(mem_out.rd) && in_ram |->
        mem_out.rd [*2] ##1 (!mem_out.rd && cpu_ack_out))
        else $error("ram read length wrong");
    fast_read_a: assert property ($rose(mem_out.rd) && fre_ff
        && mem_out.addr <= 16'hbfff |=> !mem_out.rd && cpu_ack_out)
        else $error("fast flash read not one clock");
    core_read_a: assert property ($rose(mem_out.rd) && in_core |->
        mem_out.rd [*3] ##1 (!mem_out.rd && cpu_ack_out))
        else $error("core read wait wrong");
    late_write_a: assert property ($rose(mem_out.wr) && in_ram
        && !ewr_ff |-> mem_out.wr [*2] ##1 (!mem_out.wr && cpu_ack_out))
        else $error("late write length wrong");
    early_write_a: assert property ($rose(mem_out.wr) && in_ram
        && ewr_ff |-> mem_out.wr [*3] ##1 (!mem_out.wr && cpu_ack_out))
        else $error("early write length wrong");
    addr_stable_a: assert property (mem_out.rd && $past(mem_out.rd)
        |-> $stable(mem_out.addr))
        else $error("address moved within a read");
    data_hold_a: assert property (mem_out.wr && $past(mem_out.wr)
        |-> mem_out.drive && $stable(mem_out.wdata))
        else $error("write data not held");
    reg_wait_a: assert property ((avs_read_in || avs_write_in)
        && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("register access not answered");
    // main scenarios reached
    fast_c: cover property ($rose(mem_out.rd) && fre_ff);
    early_c: cover property ($rose(mem_out.wr) && ewr_ff);
    reg_c: cover property (avs_read_in && !avs_waitrequest_out);
endmodule
